// ==== src/phy_link_cfg.svh ====
// Constants for the port link-mode control block
`ifndef PHY_LINK_CFG_SVH
`define PHY_LINK_CFG_SVH

`define PORT_COUNT 8
`define CLK_MHZ 25
`define LINK_PULSE_INTERVAL_US 16000
`define LINK_PULSE_CYCLES (`LINK_PULSE_INTERVAL_US * `CLK_MHZ)
`define PULSE_CNT_W 19

`define ADDR_W 8
`define DATA_W 16
`define ADDR_PAGE_MASK 8'hF8
`define ADDR_CTRL_BASE 8'h00
`define ADDR_STAT_BASE 8'h08
`define ADDR_GLOBAL 8'h10

`define CTRL_FIBER_BIT 0
`define CTRL_FORCE_BIT 1
`define CTRL_SPEED_BIT 2
`define CTRL_DUPLEX_BIT 3
`define CTRL_MANUAL_XOVER_BIT 8
`define CTRL_AUTO_XOVER_BIT 9

`define STAT_LINK_BIT 0
`define STAT_SPEED_BIT 1
`define STAT_DUPLEX_BIT 2
`define STAT_AN_DONE_BIT 3
`define STAT_CROSSED_BIT 4
`define STAT_PD_BIT 5
`define STAT_DECODE_LSB 6

`define GLOB_TWO_SECTIONS_BIT 0
`define GLOB_STRAPS_LOADED_BIT 1

`define CTRL_RESET 16'h0000
`define READ_IDLE 16'h0000

`endif

// ==== src/phy_link_pkg.sv ====
// Types for the port link-mode control block
package phy_link_pkg;

  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_detect = 2'b01,
    st_link = 2'b11,
    st_forced = 2'b10
  } port_state_e;

  typedef enum logic [1:0] {
    st_sample = 2'b00,
    st_load = 2'b01,
    st_run = 2'b11
  } startup_e;

  typedef enum logic [1:0] {
    dec_10t = 2'b00,
    dec_100tx = 2'b01,
    dec_100fx = 2'b10
  } rx_decode_e;

endpackage : phy_link_pkg

// ==== src/port_mode_resolver.sv ====
// Per-port speed, duplex, crossover and line-signalling resolver
`timescale 1ns/1ps
`include "phy_link_cfg.svh"

module port_mode_resolver #(
  parameter int unsigned INTERVAL_CYCLES = `LINK_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic forced,
  input wire logic forced_100,
  input wire logic forced_full,
  input wire logic fiber,
  input wire logic auto_xover,
  input wire logic manual_xover,
  input wire logic flp_seen,
  input wire logic nlp_seen,
  input wire logic idle_seen,
  input wire logic partner_100,
  input wire logic partner_full,
  input wire logic signal_present,
  input wire logic tx_busy,
  output logic link_up,
  output logic speed_100,
  output logic full_duplex,
  output logic an_complete,
  output logic parallel_detected,
  output logic crossed,
  output phy_link_pkg::rx_decode_e rx_decode,
  output logic tx_idle_symbols,
  output logic tx_nlp_pulse,
  output logic tx_flp_pulse
);

  phy_link_pkg::port_state_e state_reg;
  logic [`PULSE_CNT_W-1:0] cnt_reg;
  logic tick;
  logic manual;

  assign manual = forced | fiber;
  assign tick = (cnt_reg == `PULSE_CNT_W'(INTERVAL_CYCLES - 1));

  // Link pulse interval timer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + `PULSE_CNT_W'(1);
    end
  end

  // Resolution state machine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= phy_link_pkg::st_off;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      an_complete <= 1'b0;
      parallel_detected <= 1'b0;
    end else if (!enable) begin
      state_reg <= phy_link_pkg::st_off;
      an_complete <= 1'b0;
      parallel_detected <= 1'b0;
    end else if (manual) begin
      state_reg <= phy_link_pkg::st_forced;
      speed_100 <= fiber | forced_100;
      full_duplex <= forced_full;
      an_complete <= 1'b0;
      parallel_detected <= 1'b0;
    end else begin
      case (state_reg)
        phy_link_pkg::st_detect: begin
          if (flp_seen) begin
            state_reg <= phy_link_pkg::st_link;
            speed_100 <= partner_100;
            full_duplex <= partner_full;
            an_complete <= 1'b1;
          end else if (idle_seen) begin
            state_reg <= phy_link_pkg::st_link;
            speed_100 <= 1'b1;
            full_duplex <= 1'b0;
            parallel_detected <= 1'b1;
          end else if (nlp_seen) begin
            state_reg <= phy_link_pkg::st_link;
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            parallel_detected <= 1'b1;
          end
        end
        phy_link_pkg::st_link: begin
          if (!signal_present) begin
            state_reg <= phy_link_pkg::st_detect;
            an_complete <= 1'b0;
            parallel_detected <= 1'b0;
          end
        end
        default: begin
          state_reg <= phy_link_pkg::st_detect;
        end
      endcase
    end
  end

  // Link indication and receive decoder selection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_up <= 1'b0;
      rx_decode <= phy_link_pkg::dec_10t;
    end else begin
      link_up <= (state_reg == phy_link_pkg::st_link) | ((state_reg == phy_link_pkg::st_forced) & signal_present);
      if (fiber) begin
        rx_decode <= phy_link_pkg::dec_100fx;
      end else if (speed_100) begin
        rx_decode <= phy_link_pkg::dec_100tx;
      end else begin
        rx_decode <= phy_link_pkg::dec_10t;
      end
    end
  end

  // Crossover: forced MDI, forced crossover, or hunting while in st_detect
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crossed <= 1'b0;
    end else if (!auto_xover) begin
      crossed <= manual_xover;
    end else if (tick && state_reg == phy_link_pkg::st_detect) begin
      crossed <= ~crossed;
    end
  end

  // Line signalling: idle symbols and link pulses when no frame is sent, FLP bursts in st_detect even while tx_busy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_idle_symbols <= 1'b0;
      tx_nlp_pulse <= 1'b0;
      tx_flp_pulse <= 1'b0;
    end else begin
      tx_idle_symbols <= link_up & speed_100 & ~tx_busy;
      tx_nlp_pulse <= tick & link_up & ~speed_100 & ~tx_busy;
      tx_flp_pulse <= tick & (state_reg == phy_link_pkg::st_detect);
    end
  end

  a_xover_manual: assert property (@(posedge clk) disable iff (reset)
    !auto_xover ##1 !auto_xover |-> crossed == $past(manual_xover))
    else $error("crossover does not follow manual select");

  a_an_result: assert property (@(posedge clk) disable iff (reset)
    (enable && !manual && state_reg == phy_link_pkg::st_detect && flp_seen)
      |=> an_complete && speed_100 == $past(partner_100) && full_duplex == $past(partner_full))
    else $error("negotiated result not taken from partner");

  a_pd_nlp: assert property (@(posedge clk) disable iff (reset)
    (enable && !manual && state_reg == phy_link_pkg::st_detect && !flp_seen && !idle_seen && nlp_seen)
      |=> state_reg == phy_link_pkg::st_link && !speed_100 && !full_duplex && parallel_detected)
    else $error("link pulses did not give 10 Mbps half duplex");

  a_fiber_decode: assert property (@(posedge clk) disable iff (reset)
    rx_decode == phy_link_pkg::dec_100fx |-> $past(fiber) && !an_complete)
    else $error("fiber decode without fiber select");

  a_idle_symbols: assert property (@(posedge clk) disable iff (reset)
    link_up && speed_100 && !tx_busy ##1 speed_100 |-> tx_idle_symbols)
    else $error("no idle symbols on quiet 100 Mbps line");

  a_nlp_speed: assert property (@(posedge clk) disable iff (reset)
    tx_nlp_pulse |-> $past(link_up) && !$past(speed_100) && !$past(tx_busy) ##1 !tx_nlp_pulse)
    else $error("link pulse sent at wrong time");

endmodule : port_mode_resolver

// ==== src/phy_port_link_mode_control.sv ====
// Strap sampling, port configuration registers and per-port mode resolution
`timescale 1ns/1ps
`include "phy_link_cfg.svh"

module phy_port_link_mode_control #(
  parameter int unsigned PULSE_CYCLES = `LINK_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic auto_crossover_enable_strap,
  input wire logic manual_crossover_select_strap,
  input wire logic global_fiber_select_strap,
  input wire logic section_select,
  input wire logic forced_mode_strap,
  input wire logic forced_speed_strap,
  input wire logic forced_duplex_strap,
  input wire logic [`PORT_COUNT-1:0] flp_seen,
  input wire logic [`PORT_COUNT-1:0] nlp_seen,
  input wire logic [`PORT_COUNT-1:0] idle_seen,
  input wire logic [`PORT_COUNT-1:0] partner_100,
  input wire logic [`PORT_COUNT-1:0] partner_full,
  input wire logic [`PORT_COUNT-1:0] signal_present,
  input wire logic [`PORT_COUNT-1:0] tx_busy,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`DATA_W-1:0] rdata,
  output logic two_sections,
  output logic [`PORT_COUNT-1:0] upper_section_port,
  output logic straps_loaded,
  output logic [`PORT_COUNT-1:0] link_up,
  output logic [`PORT_COUNT-1:0] speed_100,
  output logic [`PORT_COUNT-1:0] full_duplex,
  output logic [`PORT_COUNT-1:0] crossed,
  output logic [`PORT_COUNT-1:0] fiber_mode,
  output logic [`PORT_COUNT*2-1:0] rx_decode,
  output logic [`PORT_COUNT-1:0] tx_idle_symbols,
  output logic [`PORT_COUNT-1:0] tx_nlp_pulse,
  output logic [`PORT_COUNT-1:0] tx_flp_pulse
);

  localparam int STRAP_W = 7;

  phy_link_pkg::startup_e boot_reg;
  logic [STRAP_W-1:0] strap_meta_reg;
  logic [STRAP_W-1:0] strap_sync_reg;
  logic [1:0] settle_reg;
  logic s_auto;
  logic s_manual;
  logic s_fiber;
  logic s_section;
  logic s_force;
  logic s_speed;
  logic s_duplex;
  logic loading;
  logic running;
  logic ctrl_page;
  logic stat_page;
  logic [`PORT_COUNT-1:0] ctrl_auto_reg;
  logic [`PORT_COUNT-1:0] ctrl_manual_reg;
  logic [`PORT_COUNT-1:0] ctrl_fiber_reg;
  logic [`PORT_COUNT-1:0] ctrl_force_reg;
  logic [`PORT_COUNT-1:0] ctrl_speed_reg;
  logic [`PORT_COUNT-1:0] ctrl_duplex_reg;
  logic [`PORT_COUNT-1:0] an_complete;
  logic [`PORT_COUNT-1:0] parallel_detected;
  logic [`DATA_W-1:0] ctrl_word [`PORT_COUNT];
  logic [`DATA_W-1:0] stat_word [`PORT_COUNT];
  logic [`DATA_W-1:0] rdata_next;

  // Two-stage synchroniser for the strap pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= {forced_duplex_strap, forced_speed_strap, forced_mode_strap, section_select,
                         global_fiber_select_strap, manual_crossover_select_strap,
                         auto_crossover_enable_strap};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  assign {s_duplex, s_speed, s_force, s_section, s_fiber, s_manual, s_auto} = strap_sync_reg;

  // Startup: let the synchroniser settle, load straps once, then run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_reg <= phy_link_pkg::st_sample;
      settle_reg <= 2'h0;
    end else begin
      case (boot_reg)
        phy_link_pkg::st_sample: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == 2'h2) begin
            boot_reg <= phy_link_pkg::st_load;
          end
        end
        phy_link_pkg::st_load: begin
          boot_reg <= phy_link_pkg::st_run;
        end
        phy_link_pkg::st_run: begin
          boot_reg <= phy_link_pkg::st_run;
        end
        default: begin
          boot_reg <= phy_link_pkg::st_sample;
        end
      endcase
    end
  end

  assign loading = (boot_reg == phy_link_pkg::st_load);
  assign running = (boot_reg == phy_link_pkg::st_run);
  assign straps_loaded = running;

  // Section arrangement captured with the straps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      two_sections <= 1'b0;
    end else if (loading) begin
      two_sections <= s_section;
    end
  end

  assign ctrl_page = ((addr & `ADDR_PAGE_MASK) == `ADDR_CTRL_BASE);
  assign stat_page = ((addr & `ADDR_PAGE_MASK) == `ADDR_STAT_BASE);

  genvar i;
  generate
    for (i = 0; i < `PORT_COUNT; i++) begin : g_port
      // Per-port control register: strap defaults, then software owned
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ctrl_auto_reg[i] <= 1'b0;
          ctrl_manual_reg[i] <= 1'b0;
          ctrl_fiber_reg[i] <= 1'b0;
          ctrl_force_reg[i] <= 1'b0;
          ctrl_speed_reg[i] <= 1'b0;
          ctrl_duplex_reg[i] <= 1'b0;
        end else if (loading) begin
          ctrl_auto_reg[i] <= s_auto;
          ctrl_manual_reg[i] <= s_manual;
          ctrl_fiber_reg[i] <= s_fiber;
          ctrl_force_reg[i] <= s_force;
          ctrl_speed_reg[i] <= s_speed;
          ctrl_duplex_reg[i] <= s_duplex;
        end else if (running && wr && ctrl_page && addr[2:0] == 3'(i)) begin
          ctrl_auto_reg[i] <= wdata[`CTRL_AUTO_XOVER_BIT];
          ctrl_manual_reg[i] <= wdata[`CTRL_MANUAL_XOVER_BIT];
          ctrl_fiber_reg[i] <= wdata[`CTRL_FIBER_BIT];
          ctrl_force_reg[i] <= wdata[`CTRL_FORCE_BIT];
          ctrl_speed_reg[i] <= wdata[`CTRL_SPEED_BIT];
          ctrl_duplex_reg[i] <= wdata[`CTRL_DUPLEX_BIT];
        end
      end

      port_mode_resolver #(
        .INTERVAL_CYCLES(PULSE_CYCLES)
      ) u_resolver (
        .clk(clk),
        .reset(reset),
        .enable(running),
        .forced(ctrl_force_reg[i]),
        .forced_100(ctrl_speed_reg[i]),
        .forced_full(ctrl_duplex_reg[i]),
        .fiber(ctrl_fiber_reg[i]),
        .auto_xover(ctrl_auto_reg[i]),
        .manual_xover(ctrl_manual_reg[i]),
        .flp_seen(flp_seen[i]),
        .nlp_seen(nlp_seen[i]),
        .idle_seen(idle_seen[i]),
        .partner_100(partner_100[i]),
        .partner_full(partner_full[i]),
        .signal_present(signal_present[i]),
        .tx_busy(tx_busy[i]),
        .link_up(link_up[i]),
        .speed_100(speed_100[i]),
        .full_duplex(full_duplex[i]),
        .an_complete(an_complete[i]),
        .parallel_detected(parallel_detected[i]),
        .crossed(crossed[i]),
        .rx_decode(rx_decode[2*i +: 2]),
        .tx_idle_symbols(tx_idle_symbols[i]),
        .tx_nlp_pulse(tx_nlp_pulse[i]),
        .tx_flp_pulse(tx_flp_pulse[i])
      );

      // Upper four ports form the second section when split
      assign upper_section_port[i] = two_sections & (i >= (`PORT_COUNT / 2));

      always_comb begin
        ctrl_word[i] = `CTRL_RESET;
        ctrl_word[i][`CTRL_AUTO_XOVER_BIT] = ctrl_auto_reg[i];
        ctrl_word[i][`CTRL_MANUAL_XOVER_BIT] = ctrl_manual_reg[i];
        ctrl_word[i][`CTRL_FIBER_BIT] = ctrl_fiber_reg[i];
        ctrl_word[i][`CTRL_FORCE_BIT] = ctrl_force_reg[i];
        ctrl_word[i][`CTRL_SPEED_BIT] = ctrl_speed_reg[i];
        ctrl_word[i][`CTRL_DUPLEX_BIT] = ctrl_duplex_reg[i];
        stat_word[i] = `READ_IDLE;
        stat_word[i][`STAT_LINK_BIT] = link_up[i];
        stat_word[i][`STAT_SPEED_BIT] = speed_100[i];
        stat_word[i][`STAT_DUPLEX_BIT] = full_duplex[i];
        stat_word[i][`STAT_AN_DONE_BIT] = an_complete[i];
        stat_word[i][`STAT_CROSSED_BIT] = crossed[i];
        stat_word[i][`STAT_PD_BIT] = parallel_detected[i];
        stat_word[i][`STAT_DECODE_LSB +: 2] = rx_decode[2*i +: 2];
      end
    end
  endgenerate

  assign fiber_mode = ctrl_fiber_reg;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_next = `READ_IDLE;
    if (ctrl_page) begin
      rdata_next = ctrl_word[addr[2:0]];
    end else if (stat_page) begin
      rdata_next = stat_word[addr[2:0]];
    end else if (addr == `ADDR_GLOBAL) begin
      rdata_next[`GLOB_TWO_SECTIONS_BIT] = two_sections;
      rdata_next[`GLOB_STRAPS_LOADED_BIT] = running;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= `READ_IDLE;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `READ_IDLE;
    end
  end

  a_no_early_bringup: assert property (@(posedge clk) disable iff (reset)
    !running |-> link_up == '0 && tx_flp_pulse == '0)
    else $error("port active before straps loaded");

  a_strap_xover_load: assert property (@(posedge clk) disable iff (reset)
    loading |=> ctrl_auto_reg == {`PORT_COUNT{$past(s_auto)}} && ctrl_manual_reg == {`PORT_COUNT{$past(s_manual)}})
    else $error("crossover straps not loaded into every port");

  a_strap_fiber_load: assert property (@(posedge clk) disable iff (reset)
    loading |=> ctrl_fiber_reg == {`PORT_COUNT{$past(s_fiber)}})
    else $error("fiber strap not loaded into every port");

  a_section_decode: assert property (@(posedge clk) disable iff (reset)
    running |-> upper_section_port == (two_sections ? 8'hF0 : 8'h00))
    else $error("section grouping wrong");

  a_boot_timing: assert property (@(posedge clk) disable iff (reset)
    $rose(running) |-> $past(loading) && $past(boot_reg, 2) == phy_link_pkg::st_sample)
    else $error("startup sequence skipped strap load");

  a_fiber_alike: assert property (@(posedge clk) disable iff (reset)
    $rose(running) |-> fiber_mode == {`PORT_COUNT{fiber_mode[0]}})
    else $error("strapped fiber select differs between ports");

  a_strap_manual_load: assert property (@(posedge clk) disable iff (reset)
    loading |=> ctrl_manual_reg == {`PORT_COUNT{$past(s_manual)}})
    else $error("manual crossover strap not loaded into every port");

  a_early_write: assert property (@(posedge clk) disable iff (reset)
    !running && !loading && wr |=> ctrl_fiber_reg == $past(ctrl_fiber_reg) && ctrl_auto_reg == $past(ctrl_auto_reg))
    else $error("register write taken before straps loaded");

  a_ctrl_readback: assert property (@(posedge clk) disable iff (reset)
    rd && ctrl_page |=> rdata[`CTRL_FIBER_BIT] == $past(ctrl_fiber_reg[addr[2:0]]))
    else $error("fiber select bit reads back wrong");

  a_forced_speed: assert property (@(posedge clk) disable iff (reset)
    running |=> (speed_100 & $past(ctrl_force_reg & ~ctrl_fiber_reg))
      == $past(ctrl_speed_reg & ctrl_force_reg & ~ctrl_fiber_reg))
    else $error("forced port speed differs from configuration");

  a_fiber_speed: assert property (@(posedge clk) disable iff (reset)
    running |=> (speed_100 & $past(ctrl_fiber_reg)) == $past(ctrl_fiber_reg))
    else $error("fiber port not at 100 Mbps");

  a_section_capture: assert property (@(posedge clk) disable iff (reset)
    loading |=> two_sections == $past(s_section))
    else $error("section strap not captured");

endmodule : phy_port_link_mode_control

// ==== verification/link_partner_model.sv ====
// Behavioural link partner feeding the eight line ports
`timescale 1ns/1ps
module link_partner_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] mode,
  input wire logic [7:0] abil_100,
  input wire logic [7:0] abil_full,
  input wire logic [7:0] tx_flp_pulse,
  output logic [7:0] flp_seen,
  output logic [7:0] nlp_seen,
  output logic [7:0] idle_seen,
  output logic [7:0] partner_100,
  output logic [7:0] partner_full,
  output logic [7:0] signal_present
);
  logic [7:0] an_mask;
  logic [7:0] heard1_reg;
  logic [7:0] heard_reg;
  // Mode per port: 0 silent, 1 negotiating, 2 link pulses, 3 idle symbols
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      an_mask[i] = mode[2*i +: 2] == 2'h1;
      signal_present[i] = mode[2*i +: 2] != 2'h0;
      nlp_seen[i] = mode[2*i +: 2] == 2'h2;
      idle_seen[i] = mode[2*i +: 2] == 2'h3;
    end
  end
  // Answers a burst only after hearing one, two cycles late
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      heard1_reg <= 8'h00;
      heard_reg <= 8'h00;
    end else begin
      heard1_reg <= tx_flp_pulse & an_mask;
      heard_reg <= (heard_reg | heard1_reg) & an_mask;
    end
  end
  // Abilities are garbage while no burst is being answered
  assign flp_seen = heard_reg;
  assign partner_100 = heard_reg & abil_100 | ~heard_reg & ~abil_100;
  assign partner_full = heard_reg & abil_full | ~heard_reg & ~abil_full;
endmodule : link_partner_model

// ==== verification/phy_port_link_mode_control_tb.sv ====
// Self-checking bench for the port link-mode control block
`timescale 1ns/1ps
`include "phy_link_cfg.svh"
module phy_port_link_mode_control_tb;
  localparam int PC = 16;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [6:0] strap = 7'h00;
  logic [15:0] mode = 16'h0000;
  logic [7:0] abil_100 = 8'h00;
  logic [7:0] abil_full = 8'h00;
  logic [7:0] tx_busy = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [15:0] rdata, rx_decode;
  logic two_sections, straps_loaded;
  logic [7:0] upper_section_port, link_up, speed_100, full_duplex, crossed, fiber_mode;
  logic [7:0] tx_idle_symbols, tx_nlp_pulse, tx_flp_pulse;
  logic [7:0] flp_seen, nlp_seen, idle_seen, partner_100, partner_full, signal_present;
  int n_mismatch = 0;
  int total_checks = 0;
  always #20 clk = ~clk;
  phy_port_link_mode_control #(.PULSE_CYCLES(PC)) i_dut (
    .clk, .reset, .auto_crossover_enable_strap(strap[0]), .manual_crossover_select_strap(strap[1]),
    .global_fiber_select_strap(strap[2]), .section_select(strap[3]), .forced_mode_strap(strap[4]),
    .forced_speed_strap(strap[5]), .forced_duplex_strap(strap[6]), .flp_seen, .nlp_seen, .idle_seen,
    .partner_100, .partner_full, .signal_present, .tx_busy, .addr, .wdata, .wr, .rd, .rdata,
    .two_sections, .upper_section_port, .straps_loaded, .link_up, .speed_100, .full_duplex,
    .crossed, .fiber_mode, .rx_decode, .tx_idle_symbols, .tx_nlp_pulse, .tx_flp_pulse
  );
  link_partner_model i_partner (
    .clk, .reset, .mode, .abil_100, .abil_full, .tx_flp_pulse, .flp_seen, .nlp_seen, .idle_seen,
    .partner_100, .partner_full, .signal_present
  );
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic do_reset(input logic [6:0] s);
    @(posedge clk);
    reset <= 1'h1;
    strap <= s;
    mode <= 16'h0000;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    wr_reg(8'h03, 16'hFFFF);
    for (int i = 0; i < 20 && straps_loaded !== 1'h1; i++) @(posedge clk);
    @(negedge clk);
    check("loaded", {15'h0000, straps_loaded}, 16'h0001);
  endtask : do_reset
  task automatic wait_link(input int p);
    for (int i = 0; i < 300 && link_up[p] !== 1'h1; i++) @(negedge clk);
  endtask : wait_link
  task automatic count_nlp(input int p, output int n);
    n = 0;
    repeat (4 * PC) begin
      @(negedge clk);
      n += int'(tx_nlp_pulse[p] === 1'h1);
    end
  endtask : count_nlp
  task automatic t_fiber_straps();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      rd_reg(8'(i), d);
      check("ctrl", d & 16'h0301, 16'h0101);
    end
    rd_reg(8'h10, d);
    check("global", d & 16'h0003, 16'h0003);
    check("upper", {8'h00, upper_section_port}, 16'h00F0);
    check("sections", {15'h0000, two_sections}, 16'h0001);
    check("fiber", {8'h00, fiber_mode}, 16'h00FF);
    check("decode", rx_decode, 16'hAAAA);
    check("speed", {8'h00, speed_100}, 16'h00FF);
    check("cross", {8'h00, crossed}, 16'h00FF);
    @(posedge clk);
    mode <= 16'h5555;
    repeat (4 * PC) @(negedge clk);
    check("fiber kept", {8'h00, fiber_mode}, 16'h00FF);
    check("link", {8'h00, link_up}, 16'h00FF);
  endtask : t_fiber_straps
  task automatic t_negotiate();
    logic [15:0] d;
    int n;
    rd_reg(8'h03, d);
    check("ctrl", d & 16'h0301, 16'h0200);
    rd_reg(8'h10, d);
    check("global", d & 16'h0003, 16'h0002);
    check("upper", {8'h00, upper_section_port}, 16'h0000);
    @(posedge clk);
    mode <= 16'h0579;
    abil_100 <= 8'h11;
    abil_full <= 8'h21;
    for (int p = 0; p < 6; p++) wait_link(p);
    check("speed", {8'h00, speed_100 & 8'h3F}, 16'h0015);
    check("duplex", {8'h00, full_duplex & 8'h3F}, 16'h0021);
    check("decode", rx_decode & 16'h0FFF, 16'h0111);
    rd_reg(8'h08, d);
    check("an stat", d & 16'h0029, 16'h0009);
    rd_reg(8'h0A, d);
    check("pd stat", d & 16'h0029, 16'h0021);
    check("idle", {8'h00, tx_idle_symbols & 8'h3F}, 16'h0015);
    @(posedge clk);
    tx_busy <= 8'h0B;
    repeat (3) @(negedge clk);
    check("idle busy", {8'h00, tx_idle_symbols & 8'h3F}, 16'h0014);
    count_nlp(1, n);
    check("nlp busy", 16'(n), 16'h0000);
    @(posedge clk);
    tx_busy <= 8'h00;
    count_nlp(1, n);
    check("nlp quiet", 16'(n >= 2), 16'h0001);
  endtask : t_negotiate
  task automatic t_registers();
    logic [15:0] d;
    wr_reg(8'h06, 16'h0001);
    wr_reg(8'h07, 16'h010A);
    @(posedge clk);
    mode <= mode | 16'hC000;
    repeat (4) @(negedge clk);
    check("fiber mix", {8'h00, fiber_mode}, 16'h0040);
    check("decode fx", {14'h0000, rx_decode[13:12]}, 16'h0002);
    check("forced", {13'h0000, link_up[7], speed_100[7], full_duplex[7]}, 16'h0005);
    check("manual cross", {15'h0000, crossed[7]}, 16'h0001);
    rd_reg(8'h07, d);
    check("ctrl back", d & 16'h030F, 16'h010A);
    wr_reg(8'h10, 16'h0001);
    rd_reg(8'h10, d);
    check("global ro", d & 16'h0003, 16'h0002);
    rd_reg(8'h40, d);
    check("unmapped", d, 16'h0000);
  endtask : t_registers
  task automatic t_auto_xover();
    int n;
    logic c;
    n = 0;
    wr_reg(8'h07, 16'h0200);
    @(posedge clk);
    mode <= mode & 16'h3FFF;
    @(negedge clk);
    c = crossed[7];
    repeat (4 * PC) begin
      @(negedge clk);
      n += int'(crossed[7] !== c);
      c = crossed[7];
    end
    check("hunt", 16'(n >= 2), 16'h0001);
  endtask : t_auto_xover
  task automatic t_forced_strap();
    logic [7:0] f;
    f = 8'h00;
    @(posedge clk);
    mode <= 16'h5555;
    abil_100 <= 8'hFF;
    abil_full <= 8'h00;
    repeat (4 * PC) begin
      @(negedge clk);
      f |= tx_flp_pulse;
    end
    check("no flp", {8'h00, f}, 16'h0000);
    check("link", {8'h00, link_up}, 16'h00FF);
    check("speed", {8'h00, speed_100}, 16'h0000);
    check("duplex", {8'h00, full_duplex}, 16'h00FF);
    check("cross", {8'h00, crossed}, 16'h0000);
  endtask : t_forced_strap
  initial begin
    do_reset(7'h0E);
    t_fiber_straps();
    do_reset(7'h01);
    t_negotiate();
    t_registers();
    t_auto_xover();
    do_reset(7'h50);
    t_forced_strap();
    stop_test();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule : phy_port_link_mode_control_tb
